//--- src/gpio_port_pkg.sv
// shared constants, register map and bus carrier for the shared i/o port
// assumes one 40 MHz clock and a synchronous active-high reset everywhere
package gpio_port_pkg;

    // port geometry
    localparam int PIN_COUNT = 26;
    localparam int CN_COUNT = 22;
    localparam int CN_LOW_W = 16;
    localparam int IN_FUNCS = 23;
    localparam int MAP_W = 5;
    localparam int OUT_CODES = 32;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_STRIDE = 4;

    // register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 10'h000;
    localparam logic [ADDR_W-1:0] OFS_LATCH = 10'h004;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 10'h008;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 10'h00C;
    localparam logic [ADDR_W-1:0] OFS_ANALOG = 10'h010;
    localparam logic [ADDR_W-1:0] OFS_CN_EN_LOW = 10'h014;
    localparam logic [ADDR_W-1:0] OFS_CN_EN_HIGH = 10'h018;
    localparam logic [ADDR_W-1:0] OFS_PU_EN_LOW = 10'h01C;
    localparam logic [ADDR_W-1:0] OFS_PU_EN_HIGH = 10'h020;
    localparam logic [ADDR_W-1:0] OFS_CN_STATUS = 10'h024;
    localparam logic [ADDR_W-1:0] MAP_IN_BASE = 10'h040;
    localparam logic [ADDR_W-1:0] MAP_OUT_BASE = 10'h0C0;

    // reset values and field codes
    localparam logic [MAP_W-1:0] IN_MAP_RESET = 5'h1F;
    localparam logic [MAP_W-1:0] OUT_MAP_NULL = 5'h00;
    localparam int CN_FLAG_BIT = 0;

    // one register bus request, sampled on the rising clock edge
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage

//--- src/shared_io_port.sv
// shared i/o port: direction, latch, open drain, analog readback, change notify, pin remap
// assumes pins are asynchronous inputs taken through two sync stages, registers on a plain strobe port, read data one cycle later
//
// How it works
// - driving peripheral disables port driver, pin readable
// - idle enabled peripheral lets port drive
// - port output never loops into peripheral input
// - direction 1 is input, resets input
// - latch reads latch, level reads pins, both write latch
// - unimplemented bits disabled, read zero in direction, latch and level
// - open drain bit drives low only
// - analog pins read zero in level register
// - selected input change raises interrupt request
// - up to 22 individually selectable change inputs
// - two enable registers gate change interrupts
// - two registers switch on weak pull-ups
// - remapped peripherals unconnected until assigned
// - active remapped peripheral wins over digital functions
// - analog function beats remapped peripheral
// - remap over fixed subset up to 26 pins
// - change inputs and others never remapped
// - 5-bit field picks input function pin
// - output select zero means disconnected
// - input maps reset ones, output maps zero
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module shared_io_port #(
    parameter int NUM_PINS = gpio_port_pkg::PIN_COUNT,
    parameter logic [gpio_port_pkg::PIN_COUNT-1:0] IMPL_MASK = '1
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire gpio_port_pkg::bus_req_t I_BUS,
    output logic [gpio_port_pkg::DATA_W-1:0] O_RDATA,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] I_PAD_IN,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] O_PAD_OUT,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] O_PAD_OE,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] O_PULLUP_EN,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] I_FIX_OE,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] I_FIX_OUT,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] O_FIX_IN,
    input wire logic [gpio_port_pkg::OUT_CODES-1:0] I_RP_OE,
    input wire logic [gpio_port_pkg::OUT_CODES-1:0] I_RP_OUT,
    output logic [gpio_port_pkg::IN_FUNCS-1:0] O_RP_IN,
    output logic O_CN_IRQ
);
    import gpio_port_pkg::*;

    // software-visible state
    logic [PIN_COUNT-1:0] dir_r, dir_nxt, lat_r, lat_nxt, od_r, od_nxt, ana_r, ana_nxt;
    logic [CN_COUNT-1:0] cn_en_r, cn_en_nxt, pu_en_r, pu_en_nxt;
    logic [MAP_W-1:0] in_map_r [IN_FUNCS];
    logic [MAP_W-1:0] in_map_nxt [IN_FUNCS];
    logic [MAP_W-1:0] out_map_r [PIN_COUNT];
    logic [MAP_W-1:0] out_map_nxt [PIN_COUNT];
    logic cn_flag_r, cn_flag_nxt;
    logic [DATA_W-1:0] rdata_nxt;

    // pin sampling and change detection state
    logic [PIN_COUNT-1:0] sync1_r, sync2_r;
    logic [CN_COUNT-1:0] cn_prev_r;
    logic cn_armed_r;
    logic cn_hit, cn_clear;
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] sync1_nxt, sync2_nxt, pullup_nxt;
    logic [CN_COUNT-1:0] cn_prev_nxt;

    // per-pin drive and peripheral input results
    logic [PIN_COUNT-1:0] pad_out_nxt, pad_oe_nxt, fix_in_nxt, port_own;
    logic [OUT_CODES-1:0] remap_src;
    logic [IN_FUNCS-1:0] rp_in_nxt;

    // analog pins and unimplemented bits never show a digital level
    assign pin_level = sync2_r & ~ana_r & IMPL_MASK;

    // change detect: compare the settled sample with the one before it
    assign cn_hit = cn_armed_r
        & (|((sync2_r[CN_COUNT-1:0] ^ cn_prev_r) & cn_en_r));
    assign cn_clear = I_BUS.wr & (I_BUS.addr == OFS_CN_STATUS) & I_BUS.wdata[CN_FLAG_BIT];

    // per-pin output ownership: remap, then fixed peripheral, then port
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        logic [MAP_W-1:0] code;
        logic rp_act, fix_act, port_act, drive, val;
        assign code = out_map_r[p];
        // a null code or an analog pin keeps the remapped output off
        assign rp_act = (code != OUT_MAP_NULL) & I_RP_OE[code]
            & ~ana_r[p];
        assign fix_act = I_FIX_OE[p] & ~rp_act;
        assign port_act = ~dir_r[p] & ~rp_act & ~fix_act;
        assign drive = IMPL_MASK[p] & (rp_act | fix_act | port_act);
        assign val = rp_act ? I_RP_OUT[code] : (fix_act ? I_FIX_OUT[p] : lat_r[p]);
        // open drain: a high level releases the pin instead of driving it
        assign pad_oe_nxt[p] = drive & ~(od_r[p] & val);
        assign pad_out_nxt[p] = val & ~od_r[p];
        assign port_own[p] = port_act & IMPL_MASK[p];
        // the port's own drive is masked from the peripheral input
        assign fix_in_nxt[p] = pin_level[p] & ~port_own[p];
    end

    // remap input source: pins beyond the real ones (pin 31 after reset) read low
    assign remap_src = OUT_CODES'(pin_level & ~port_own);

    for (genvar f = 0; f < IN_FUNCS; f++) begin : g_in_func
        assign rp_in_nxt[f] = remap_src[in_map_r[f]];
    end

    // register writes and read data
    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        od_nxt = od_r;
        ana_nxt = ana_r;
        cn_en_nxt = cn_en_r;
        pu_en_nxt = pu_en_r;
        in_map_nxt = in_map_r;
        out_map_nxt = out_map_r;
        rdata_nxt = '0;
        if (I_BUS.wr) begin
            unique case (I_BUS.addr)
                OFS_DIRECTION: dir_nxt = I_BUS.wdata[PIN_COUNT-1:0];
                OFS_LATCH, OFS_LEVEL: lat_nxt = I_BUS.wdata[PIN_COUNT-1:0];
                OFS_OPEN_DRAIN: od_nxt = I_BUS.wdata[PIN_COUNT-1:0];
                OFS_ANALOG: ana_nxt = I_BUS.wdata[PIN_COUNT-1:0];
                OFS_CN_EN_LOW: cn_en_nxt[CN_LOW_W-1:0] = I_BUS.wdata[CN_LOW_W-1:0];
                OFS_CN_EN_HIGH: begin
                    cn_en_nxt[CN_COUNT-1:CN_LOW_W] = I_BUS.wdata[CN_COUNT-CN_LOW_W-1:0];
                end
                OFS_PU_EN_LOW: pu_en_nxt[CN_LOW_W-1:0] = I_BUS.wdata[CN_LOW_W-1:0];
                OFS_PU_EN_HIGH: begin
                    pu_en_nxt[CN_COUNT-1:CN_LOW_W] = I_BUS.wdata[CN_COUNT-CN_LOW_W-1:0];
                end
                default: ;
            endcase
            for (int k = 0; k < IN_FUNCS; k++) begin
                if (I_BUS.addr == MAP_IN_BASE + ADDR_W'(REG_STRIDE * k)) begin
                    in_map_nxt[k] = I_BUS.wdata[MAP_W-1:0];
                end
            end
            for (int k = 0; k < PIN_COUNT; k++) begin
                if (I_BUS.addr == MAP_OUT_BASE + ADDR_W'(REG_STRIDE * k)) begin
                    out_map_nxt[k] = I_BUS.wdata[MAP_W-1:0];
                end
            end
        end
        if (I_BUS.rd) begin
            unique case (I_BUS.addr)
                OFS_DIRECTION: rdata_nxt = DATA_W'(dir_r & IMPL_MASK);
                OFS_LATCH: rdata_nxt = DATA_W'(lat_r & IMPL_MASK);
                OFS_LEVEL: rdata_nxt = DATA_W'(pin_level);
                OFS_OPEN_DRAIN: rdata_nxt = DATA_W'(od_r);
                OFS_ANALOG: rdata_nxt = DATA_W'(ana_r);
                OFS_CN_EN_LOW: rdata_nxt = DATA_W'(cn_en_r[CN_LOW_W-1:0]);
                OFS_CN_EN_HIGH: rdata_nxt = DATA_W'(cn_en_r[CN_COUNT-1:CN_LOW_W]);
                OFS_PU_EN_LOW: rdata_nxt = DATA_W'(pu_en_r[CN_LOW_W-1:0]);
                OFS_PU_EN_HIGH: rdata_nxt = DATA_W'(pu_en_r[CN_COUNT-1:CN_LOW_W]);
                OFS_CN_STATUS: rdata_nxt = DATA_W'(cn_flag_r);
                default: ;
            endcase
            for (int k = 0; k < IN_FUNCS; k++) begin
                if (I_BUS.addr == MAP_IN_BASE + ADDR_W'(REG_STRIDE * k)) begin
                    rdata_nxt = DATA_W'(in_map_r[k]);
                end
            end
            for (int k = 0; k < PIN_COUNT; k++) begin
                if (I_BUS.addr == MAP_OUT_BASE + ADDR_W'(REG_STRIDE * k)) begin
                    rdata_nxt = DATA_W'(out_map_r[k]);
                end
            end
        end
    end

    // change flag: a change in the clear cycle still sets it
    always_comb begin
        cn_flag_nxt = cn_flag_r;
        if (cn_clear) begin
            cn_flag_nxt = 1'b0;
        end
        if (cn_hit) begin
            cn_flag_nxt = 1'b1;
        end
    end

    // registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            dir_r <= '1;
            lat_r <= '0;
            od_r <= '0;
            ana_r <= '0;
            cn_en_r <= '0;
            pu_en_r <= '0;
            for (int k = 0; k < IN_FUNCS; k++) begin
                in_map_r[k] <= IN_MAP_RESET;
            end
            for (int k = 0; k < PIN_COUNT; k++) begin
                out_map_r[k] <= OUT_MAP_NULL;
            end
            cn_flag_r <= 1'b0;
            O_RDATA <= '0;
        end else begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            od_r <= od_nxt;
            ana_r <= ana_nxt;
            cn_en_r <= cn_en_nxt;
            pu_en_r <= pu_en_nxt;
            in_map_r <= in_map_nxt;
            out_map_r <= out_map_nxt;
            cn_flag_r <= cn_flag_nxt;
            O_RDATA <= rdata_nxt;
        end
    end

    // pin sampling next values; change inputs tap the pins, never the remap network
    always_comb begin
        sync1_nxt = I_PAD_IN;
        sync2_nxt = sync1_r;
        cn_prev_nxt = sync2_r[CN_COUNT-1:0];
    end

    // pin sampling; prev is not compared in the cycle after reset to avoid a false change
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sync1_r <= '0;
            sync2_r <= '0;
            cn_prev_r <= '0;
            cn_armed_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            cn_prev_r <= cn_prev_nxt;
            cn_armed_r <= 1'b1;
        end
    end

    // pull-ups exist only on the change inputs; the upper pins have none to switch
    assign pullup_nxt = PIN_COUNT'(pu_en_r) & IMPL_MASK;

    // pad and peripheral outputs, all registered
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_PAD_OUT <= '0;
            O_PAD_OE <= '0;
            O_PULLUP_EN <= '0;
            O_FIX_IN <= '0;
            O_RP_IN <= '0;
            O_CN_IRQ <= 1'b0;
        end else begin
            O_PAD_OUT <= pad_out_nxt;
            O_PAD_OE <= pad_oe_nxt;
            O_PULLUP_EN <= pullup_nxt;
            O_FIX_IN <= fix_in_nxt;
            O_RP_IN <= rp_in_nxt;
            O_CN_IRQ <= cn_flag_nxt;
        end
    end

    // checks
    a_dir_after_reset: assert property (@(posedge I_CLK) I_RESET |=> dir_r == '1)
        else $error("direction not input after reset");
    a_map_after_reset: assert property (@(posedge I_CLK)
        I_RESET |=> (in_map_r[0] == IN_MAP_RESET) && (out_map_r[0] == OUT_MAP_NULL))
        else $error("map fields wrong after reset");
    a_level_writes_latch: assert property (@(posedge I_CLK) disable iff (I_RESET)
        I_BUS.wr && I_BUS.addr == OFS_LEVEL |=> lat_r == $past(I_BUS.wdata[PIN_COUNT-1:0]))
        else $error("level write missed latch");
    a_level_read_sync: assert property (@(posedge I_CLK) disable iff (I_RESET)
        I_BUS.rd && I_BUS.addr == OFS_LEVEL |=> O_RDATA == DATA_W'($past(pin_level)))
        else $error("level read not from synchronised pins");
    a_analog_reads_low: assert property (@(posedge I_CLK) disable iff (I_RESET)
        I_BUS.rd && I_BUS.addr == OFS_LEVEL |=> (O_RDATA & DATA_W'($past(ana_r))) == '0)
        else $error("analog pin read high");
    a_open_drain_high: assert property (@(posedge I_CLK) disable iff (I_RESET)
        ##1 (O_PAD_OE & O_PAD_OUT & $past(od_r)) == '0)
        else $error("open drain pin drove high");
    a_unimpl_quiet: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (O_PAD_OE & ~IMPL_MASK) == '0)
        else $error("unimplemented pin driven");
    a_change_raises: assert property (@(posedge I_CLK) disable iff (I_RESET)
        cn_hit |=> O_CN_IRQ && cn_flag_r)
        else $error("change did not raise request");
    a_flag_holds: assert property (@(posedge I_CLK) disable iff (I_RESET)
        cn_flag_r && !cn_clear |=> cn_flag_r)
        else $error("change flag dropped without clear");
    a_input_default_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
        in_map_r[0] == IN_MAP_RESET |=> !O_RP_IN[0])
        else $error("unassigned remap input not low");
    a_fixed_drives: assert property (@(posedge I_CLK) disable iff (I_RESET)
        I_FIX_OE[1] && IMPL_MASK[1] && !od_r[1] && out_map_r[1] == OUT_MAP_NULL
        |=> O_PAD_OE[1] && (O_PAD_OUT[1] == $past(I_FIX_OUT[1])))
        else $error("fixed peripheral lost its pin");
    a_analog_no_remap: assert property (@(posedge I_CLK) disable iff (I_RESET)
        1'b1 |=> (O_PAD_OE & $past(ana_r & dir_r & ~I_FIX_OE)) == '0)
        else $error("analog input pin driven");
    a_clear_drops: assert property (@(posedge I_CLK) disable iff (I_RESET)
        cn_clear && !cn_hit |=> !O_CN_IRQ)
        else $error("request stayed after clear");

endmodule
`default_nettype wire

//--- tb/board_model.sv
// board side of the port: resolves each pad from device drive, board drive and pull-up
// assumes the bench gives the board drive and only looks at settled pad levels
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input wire logic i_clk,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] i_oe,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] i_out,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] i_pu,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] i_ext_en,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] i_ext_val,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] o_pad
);
    import gpio_port_pkg::*;
    logic [PIN_COUNT-1:0] last_r;
    // a floating pad shows the inverse of its last level, so a stale value never passes
    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (i_oe[p]) o_pad[p] = i_out[p];
            else if (i_ext_en[p]) o_pad[p] = i_ext_val[p];
            else if (i_pu[p]) o_pad[p] = 1'b1;
            else o_pad[p] = ~last_r[p];
        end
    end
    always_ff @(posedge i_clk) last_r <= o_pad;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the shared i/o port: strobe bus tasks plus pin and peripheral stimulus
// assumes one 40 MHz clock and read data standing only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpio_port_pkg::*;
    localparam logic [PIN_COUNT-1:0] IMPL = 26'h1FF_FFFF; // top pin left unimplemented
    logic clk = 1'b0;
    logic rst = 1'b1;
    bus_req_t bus = '0;
    logic [DATA_W-1:0] rdata, got;
    logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pu, fix_in;
    logic [PIN_COUNT-1:0] fix_oe = '0, fix_out = '0, ext_en = '1, ext_val = 26'h155_5555;
    logic [OUT_CODES-1:0] rp_oe = '0, rp_out = '0;
    logic [IN_FUNCS-1:0] rp_in;
    logic irq;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    shared_io_port #(.IMPL_MASK(IMPL)) dut (.I_CLK(clk), .I_RESET(rst), .I_BUS(bus),
        .O_RDATA(rdata), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe),
        .O_PULLUP_EN(pu), .I_FIX_OE(fix_oe), .I_FIX_OUT(fix_out), .O_FIX_IN(fix_in),
        .I_RP_OE(rp_oe), .I_RP_OUT(rp_out), .O_RP_IN(rp_in), .O_CN_IRQ(irq));
    board_model board (.i_clk(clk), .i_oe(pad_oe), .i_out(pad_out), .i_pu(pu),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad_in));

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // each access starts just after an edge, so the strobe is never assigned twice at once
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge clk);
        bus <= '0;
        #1;
        got = rdata;
        chk(got, exp);
    endtask
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(2);
        rchk(OFS_DIRECTION, 32'h01FF_FFFF);
        rchk(OFS_LATCH, 32'h0000_0000);
        rchk(MAP_IN_BASE, 32'h0000_001F);
        rchk(MAP_OUT_BASE + 10'h004, 32'h0000_0000);
        rchk(10'h3F0, 32'h0000_0000);
        chk(32'(pad_oe), 32'h0000_0000);
        chk(32'(rp_in), 32'h0000_0000);
        $display("test reset done");
        // writing the level register lands in the latch; low byte becomes outputs
        wr(OFS_LEVEL, 32'h0000_00A5);
        wr(OFS_DIRECTION, 32'h03FF_FF00);
        step(3);
        rchk(OFS_LATCH, 32'h0000_00A5);
        rchk(OFS_LEVEL, 32'h0155_55A5);
        chk(32'(pad_oe), 32'h0000_00FF);
        chk(32'(pad_out & 26'hFF), 32'h0000_00A5);
        chk(32'({fix_in[7], fix_in[20]}), 32'h0000_0001);
        wr(OFS_PU_EN_LOW, 32'h0000_FF00);
        wr(OFS_PU_EN_HIGH, 32'h0000_003F);
        step(1);
        chk(32'(pu), 32'h003F_FF00);
        $display("test latch done");
        wr(OFS_OPEN_DRAIN, 32'h0000_0001);
        step(1);
        chk(32'(pad_oe[0]), 32'h0000_0000);
        wr(OFS_LATCH, 32'h0000_00A4);
        step(1);
        chk(32'({pad_oe[0], pad_out[0]}), 32'h0000_0002);
        $display("test open drain done");
        // fixed peripheral takes pin 1 from the port, then hands it back
        fix_oe[1] <= 1'b1;
        fix_out[1] <= 1'b1;
        step(1);
        chk(32'({pad_oe[1], pad_out[1]}), 32'h0000_0003);
        step(2);
        rchk(OFS_LEVEL, 32'h0155_55A6);
        fix_oe[1] <= 1'b0;
        step(1);
        chk(32'({pad_oe[1], pad_out[1]}), 32'h0000_0002);
        $display("test fixed peripheral done");
        // pin 2: null map leaves the fixed peripheral, a mapped output wins
        fix_oe[2] <= 1'b1;
        fix_out[2] <= 1'b1;
        rp_oe[3] <= 1'b1;
        rp_out[3] <= 1'b0;
        step(1);
        chk(32'(pad_out[2]), 32'h0000_0001);
        wr(MAP_OUT_BASE + 10'h008, 32'h0000_0003);
        step(1);
        chk(32'({pad_oe[2], pad_out[2]}), 32'h0000_0002);
        fix_oe[2] <= 1'b0;
        wr(OFS_DIRECTION, 32'h03FF_FF04);
        wr(OFS_ANALOG, 32'h0000_0004);
        step(1);
        chk(32'(pad_oe[2]), 32'h0000_0000);
        step(2);
        rchk(OFS_LEVEL, 32'h0155_55A0);
        wr(MAP_IN_BASE, 32'h0000_0014);
        step(4);
        chk(32'(rp_in[0]), 32'h0000_0001);
        ext_val[20] <= 1'b0;
        step(4);
        chk(32'(rp_in[0]), 32'h0000_0000);
        $display("test remap done");
        // one shared flag: disabled pin ignored, low and high enables both count
        // pins 11 and 12 are inputs; the low byte apart from analog input pin 2 is port-driven so the board cannot move it
        wr(OFS_CN_EN_LOW, 32'h0000_0800);
        wr(OFS_CN_EN_HIGH, 32'h0000_0020);
        ext_val[12] <= 1'b0;
        step(4);
        chk(32'(irq), 32'h0000_0000);
        ext_val[11] <= 1'b1;
        step(3);
        chk(32'(irq), 32'h0000_0001);
        rchk(OFS_CN_STATUS, 32'h0000_0001);
        wr(OFS_CN_STATUS, 32'h0000_0001);
        step(1);
        chk(32'(irq), 32'h0000_0000);
        ext_val[21] <= 1'b1;
        step(3);
        chk(32'(irq), 32'h0000_0001);
        $display("test change notify done");
        print_verdict();
    end
endmodule
`default_nettype wire
